//--- hdl/irq_enable_defines.vh
// constants for the interrupt enable set/clear register block
// assumes a single ahb-lite slave window, word-aligned 32-bit registers
`ifndef IRQ_ENABLE_DEFINES_VH
`define IRQ_ENABLE_DEFINES_VH

// ***************************************************************
// register offsets (byte addresses inside the slave window)
// ***************************************************************
`define ADDR_W                12
`define OFS_SET_LOWER         12'h000
`define OFS_SET_UPPER         12'h004
`define OFS_CLEAR_LOWER       12'h008
`define OFS_CLEAR_UPPER       12'h00c

// ***************************************************************
// field layout and reset values
// ***************************************************************
`define LOWER_W               32
`define UPPER_W               14
`define UPPER_MSB             13
`define LOWER_RESET           32'h0000_0000
`define UPPER_RESET           14'h0000
`define RDATA_RESET           32'h0000_0000

// ***************************************************************
// ahb-lite encodings
// ***************************************************************
`define HTRANS_NONSEQ_BIT     1
`define HSIZE_WORD            3'h2
`define HRESP_OKAY            1'h0

`endif

//--- hdl/enable_latch_bank.v
// bank of interrupt enable latches, one per interrupt
// assumes set and clear strobes are one-cycle, already decoded per bit
`timescale 1ns/100ps
`default_nettype none
`include "irq_enable_defines.vh"

module enable_latch_bank
#(
   parameter WIDTH = 32
)
(
   input  wire             hclk,
   input  wire             hresetn,
   input  wire [WIDTH-1:0] set_bits,
   input  wire [WIDTH-1:0] clear_bits,
   output reg  [WIDTH-1:0] state_reg,
   output wire [WIDTH-1:0] state_next
);

   // ***************************************************************
   // per-bit latch
   // ***************************************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         // clear beats set so a racing write pair never leaves a stray enable
         assign state_next[i] = clear_bits[i] ? 1'b0 :
                                set_bits[i]   ? 1'b1 : state_reg[i];
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               state_reg[i] <= 1'b0;
            else
               state_reg[i] <= state_next[i];
         end
      end
   endgenerate

endmodule // enable_latch_bank

`default_nettype wire

//--- hdl/irq_enable_regs.v
// ahb-lite slave holding the interrupt enable set and clear views
// assumes one master, single word transfers, hready fed back from hreadyout
`timescale 1ns/100ps
`default_nettype none
`include "irq_enable_defines.vh"

module irq_enable_regs
(
   input  wire                  hclk,
   input  wire                  hresetn,
   input  wire                  hsel,
   input  wire [31:0]           haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire [31:0]           hwdata,
   input  wire                  hready,
   output reg                   hreadyout,
   output reg                   hresp,
   output reg  [31:0]           hrdata,
   output wire [`LOWER_W-1:0]   enable_lower,
   output wire [`UPPER_W-1:0]   enable_upper
);

   // ***************************************************************
   // address phase capture
   // ***************************************************************
   wire                 addr_valid;
   wire                 word_ok;
   wire [`ADDR_W-1:0]   addr_low;
   reg                  wr_pending_reg;
   reg  [`ADDR_W-1:0]   wr_addr_reg;
   reg                  wr_pending_next;
   reg  [`ADDR_W-1:0]   wr_addr_next;

   assign addr_low   = haddr[`ADDR_W-1:0];
   // only whole aligned words are honoured; narrower ones complete but do nothing
   assign word_ok    = (hsize == `HSIZE_WORD) && (haddr[1:0] == 2'h0);
   assign addr_valid = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready && word_ok;

   always @*
   begin
      wr_pending_next = 1'b0;
      wr_addr_next    = wr_addr_reg;
      if (addr_valid && hwrite)
      begin
         wr_pending_next = 1'b1;
         wr_addr_next    = addr_low;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pending_reg <= 1'b0;
         wr_addr_reg    <= {`ADDR_W{1'b0}};
      end
      else
      begin
         wr_pending_reg <= wr_pending_next;
         wr_addr_reg    <= wr_addr_next;
      end
   end

   // ***************************************************************
   // write decode (data phase)
   // ***************************************************************
   reg                  wr_set_lower;
   reg                  wr_set_upper;
   reg                  wr_clear_lower;
   reg                  wr_clear_upper;

   always @*
   begin
      wr_set_lower   = 1'b0;
      wr_set_upper   = 1'b0;
      wr_clear_lower = 1'b0;
      wr_clear_upper = 1'b0;
      if (wr_pending_reg)
      begin
         if (wr_addr_reg == `OFS_SET_LOWER)
            wr_set_lower = 1'b1;
         else if (wr_addr_reg == `OFS_SET_UPPER)
            wr_set_upper = 1'b1;
         else if (wr_addr_reg == `OFS_CLEAR_LOWER)
            wr_clear_lower = 1'b1;
         else if (wr_addr_reg == `OFS_CLEAR_UPPER)
            wr_clear_upper = 1'b1;
      end
   end

   // ***************************************************************
   // write data for the upper half
   // ***************************************************************
   wire [`UPPER_W-1:0]  upper_wdata;

   // bits 31..14 of a write have no latch behind them and are dropped
   assign upper_wdata = hwdata[`UPPER_MSB:0];

   // ***************************************************************
   // set and clear strobes per interrupt
   // ***************************************************************
   wire [`LOWER_W-1:0]  set_lower_bits;
   wire [`LOWER_W-1:0]  clear_lower_bits;
   wire [`UPPER_W-1:0]  set_upper_bits;
   wire [`UPPER_W-1:0]  clear_upper_bits;

   // only ones act; zeros in hwdata leave the latch alone
   assign set_lower_bits   = wr_set_lower   ? hwdata : {`LOWER_W{1'b0}};
   assign clear_lower_bits = wr_clear_lower ? hwdata : {`LOWER_W{1'b0}};
   assign set_upper_bits   = wr_set_upper   ? upper_wdata : {`UPPER_W{1'b0}};
   assign clear_upper_bits = wr_clear_upper ? upper_wdata : {`UPPER_W{1'b0}};

   // ***************************************************************
   // shared enable latches
   // ***************************************************************
   wire [`LOWER_W-1:0]  lower_next;
   wire [`UPPER_W-1:0]  upper_next;

   // set and clear views land on the same latch for each interrupt
   enable_latch_bank
   #(
      .WIDTH      (`LOWER_W)
   )
   u_lower
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .set_bits   (set_lower_bits),
      .clear_bits (clear_lower_bits),
      .state_reg  (enable_lower),
      .state_next (lower_next)
   );

   enable_latch_bank
   #(
      .WIDTH      (`UPPER_W)
   )
   u_upper
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .set_bits   (set_upper_bits),
      .clear_bits (clear_upper_bits),
      .state_reg  (enable_upper),
      .state_next (upper_next)
   );

   // ***************************************************************
   // read decode (address phase)
   // ***************************************************************
   reg                  rd_lower;
   reg                  rd_upper;

   // both views of one half read the same latches, so two offsets share a select
   always @*
   begin
      rd_lower = 1'b0;
      rd_upper = 1'b0;
      if (addr_valid && !hwrite)
      begin
         if (addr_low == `OFS_SET_LOWER)
            rd_lower = 1'b1;
         else if (addr_low == `OFS_CLEAR_LOWER)
            rd_lower = 1'b1;
         else if (addr_low == `OFS_SET_UPPER)
            rd_upper = 1'b1;
         else if (addr_low == `OFS_CLEAR_UPPER)
            rd_upper = 1'b1;
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   // read data is sampled from the next latch state, so a read that follows
   // a write back to back already sees it without a wait state
   wire [31:0]          upper_word;
   reg  [31:0]          rdata_next;

   // reserved bits 31..14 have no storage and are tied low here
   assign upper_word = {{(32-`UPPER_W){1'b0}}, upper_next};

   always @*
   begin
      rdata_next = `RDATA_RESET;
      if (rd_lower)
         rdata_next = lower_next;
      else if (rd_upper)
         rdata_next = upper_word;
   end

   // ***************************************************************
   // bus response
   // ***************************************************************
   // never stalls and never errors; unmapped words read zero, writes vanish
   // zero wait states: every transfer completes in its first data cycle
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hreadyout <= 1'b1;
      else
         hreadyout <= 1'b1;
   end

   // the slave has no error cases, so the response stays okay
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hresp <= `HRESP_OKAY;
      else
         hresp <= `HRESP_OKAY;
   end

   // hrdata drops to zero after its data phase so stale words never linger
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= `RDATA_RESET;
      else
         hrdata <= rdata_next;
   end

endmodule // irq_enable_regs

`default_nettype wire

//--- tb/irq_enable_regs_chk.sv
// checker for the interrupt enable register slave
// assumes hready is fed back from hreadyout and word transfers only
`timescale 1ns/100ps
`default_nettype none
`include "irq_enable_defines.vh"
module irq_enable_regs_chk
(
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [2:0]          hsize,
   input wire logic [31:0]         hwdata,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [31:0]         hrdata,
   input wire logic [`LOWER_W-1:0] enable_lower,
   input wire logic [`UPPER_W-1:0] enable_upper
);
   // ****************
   // data phase tracking
   // ****************
   logic        dp_reg, dw_reg;
   logic [11:0] ad_reg;
   logic [31:0] wd_reg, lo_reg;
   logic [13:0] up_reg;
   wire tk = hsel && htrans[1] && hready && hsize == 3'h2 && haddr[1:0] == 2'h0;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_reg <= 1'b0;
         dw_reg <= 1'b0;
      end
      else if (hready)
      begin
         dp_reg <= tk;
         dw_reg <= tk && hwrite;
      end
   end
   // old values kept one cycle so the next state can be judged against them
   always_ff @(posedge hclk)
   begin
      ad_reg <= hready ? haddr[11:0] : ad_reg;
      wd_reg <= hwdata;
      lo_reg <= enable_lower;
      up_reg <= enable_upper;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_set_up; dw_reg && ad_reg == 12'h004 |=> enable_upper == (up_reg | wd_reg[13:0]); endproperty
   a_set_up: assert property (p_set_up) else $error("set upper wrong");
   property p_clr_lo; dw_reg && ad_reg == 12'h008 |=> enable_lower == (lo_reg & ~wd_reg); endproperty
   a_clr_lo: assert property (p_clr_lo) else $error("clear lower wrong");
   property p_set_lo; dw_reg && ad_reg == 12'h000 |=> enable_lower == (lo_reg | wd_reg); endproperty
   a_set_lo: assert property (p_set_lo) else $error("set lower wrong");
   property p_clr_up; dw_reg && ad_reg == 12'h00c |=> enable_upper == (up_reg & ~wd_reg[13:0]); endproperty
   a_clr_up: assert property (p_clr_up) else $error("clear upper wrong");
   property p_hold; !dw_reg |=> $stable(enable_lower) && $stable(enable_upper); endproperty
   a_hold: assert property (p_hold) else $error("enables moved without write");
   property p_rd_up; dp_reg && !dw_reg && ad_reg[3:0] inside {4'h4, 4'hc} && ad_reg[11:4] == 8'h0
      |-> hrdata == {18'h0, enable_upper}; endproperty
   a_rd_up: assert property (p_rd_up) else $error("upper read wrong");
   property p_rd_lo; dp_reg && !dw_reg && ad_reg[3:0] inside {4'h0, 4'h8} && ad_reg[11:4] == 8'h0
      |-> hrdata == enable_lower; endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("lower read wrong");
   property p_rst; $rose(hresetn) |-> enable_lower == 32'h0 && enable_upper == 14'h0; endproperty
   a_rst: assert property (p_rst) else $error("enables not cleared by reset");
   c_clr: cover property (dw_reg && ad_reg == 12'h008);
   c_set: cover property (dw_reg && ad_reg == 12'h004);
   c_rd: cover property (dp_reg && !dw_reg && ad_reg == 12'h004);
endmodule // irq_enable_regs_chk
bind irq_enable_regs irq_enable_regs_chk irq_enable_regs_chk_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .enable_lower(enable_lower), .enable_upper(enable_upper));
`default_nettype wire

//--- tb/interrupt_enable_set_clear_bench.sv
// bench for the interrupt enable register slave
// assumes a single ahb-lite master, zero wait states allowed but not assumed
`timescale 1ns/100ps
`default_nettype none
module interrupt_enable_set_clear_bench;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0;
   wire         hready, hresp;
   wire [31:0]  hrdata, enable_lower;
   wire [13:0]  enable_upper;
   int          errors = 0, checks = 0;
   always #2 hclk = ~hclk;
   irq_enable_regs irq_enable_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .enable_lower(enable_lower),
      .enable_upper(enable_upper));
   // ****************
   // bus tasks
   // ****************
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // never trust a fixed latency: wait for hready, but never forever
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 64)
         begin
            errors++;
            end_of_test;
         end
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk("read data", exp, hrdata);
      chk("response", 32'h0, {31'h0, hresp});
   endtask
   // ****************
   // scenarios
   // ****************
   logic [11:0] checks_addr[4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
   task automatic t_reset;
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (checks_addr[i]) rd(checks_addr[i], 32'h0);
      chk("enable lower", 32'h0, enable_lower);
      chk("enable upper", 32'h0, {18'h0, enable_upper});
      $display("reset test done");
   endtask
   task automatic t_set_upper;
      bus(12'h004, 1'b1, 32'hffff_ffff);
      rd(12'h004, 32'h0000_3fff);
      bus(12'h004, 1'b1, 32'h0000_0000);
      rd(12'h004, 32'h0000_3fff);
      bus(12'h00c, 1'b1, 32'h0000_2001);
      rd(12'h004, 32'h0000_1ffe);
      chk("enable upper", 32'h0000_1ffe, {18'h0, enable_upper});
      $display("set upper test done");
   endtask
   task automatic t_clear_lower;
      bus(12'h000, 1'b1, 32'hffff_ffff);
      rd(12'h008, 32'hffff_ffff);
      bus(12'h008, 1'b1, 32'h0000_0000);
      rd(12'h008, 32'hffff_ffff);
      for (int i = 0; i < 32; i++)
      begin
         bus(12'h008, 1'b1, 32'h1 << i);
         rd(12'h008, 32'hffff_ffff << (i + 1));
      end
      chk("enable lower", 32'h0, enable_lower);
      $display("clear lower test done");
   endtask
   // unmapped places and byte sizes must leave the latches alone
   task automatic t_refused;
      bus(12'h010, 1'b1, 32'hffff_ffff);
      rd(12'h010, 32'h0);
      hsize <= 3'h0;
      bus(12'h000, 1'b1, 32'h0000_0001);
      hsize <= 3'h2;
      rd(12'h000, 32'h0);
      rd(12'h00c, 32'h0000_1ffe);
      $display("refused access test done");
   endtask
   initial
   begin
      t_reset;
      t_set_upper;
      t_clear_lower;
      t_refused;
      t_reset;
      end_of_test;
   end
endmodule // interrupt_enable_set_clear_bench
`default_nettype wire
